// ---- src/abu_regs.svh ----
// Register offsets, opcodes, flag positions and cycle counts of the execution unit
// Behaviour
// - Add registers, optional carry, six flags, one cycle
// - Word immediate add/subtract, flags, two cycles
// - Subtract register/constant, optional borrow, six flags
// - AND/OR/XOR update only Z, N, V
// - Set bits ORs mask; clear ANDs inverse
// - Test, zeroing set flags; all-ones keeps flags
// - Products into high/low word, Z and C, two cycles
// - Fractional products shifted left one, two cycles
// - Pointer jump/call load PC from Z
// - Relative jump/call target PC plus offset plus one
// - Equal skip, one to three cycles, no flags
// - Compares subtract without storing, six flags
// - Skip on general register bit state
// - Skip on I/O register bit state
// - Flag branch, one cycle untaken, two taken
// - Signed branches test N xor V
// - Unsigned branches test carry flag
// - Branches on global interrupt enable flag
// - Branch pairs on H, T, V flags
// - Branch pairs on Z, C, N flags
// - I/O bit ops rewrite whole register, clearing flags
// - I/O bit ops only at addresses 0x00-0x1F
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
`define ABU_OFS_CMD      8'h00
`define ABU_OFS_OPA      8'h04
`define ABU_OFS_OPB      8'h08
`define ABU_OFS_PC       8'h0C
`define ABU_OFS_ZPTR     8'h10
`define ABU_OFS_STATUS_REGISTER     8'h14
`define ABU_OFS_RESULT   8'h18
`define ABU_OFS_STAT     8'h1C
`define ABU_OFS_W1C      8'h20
`define ABU_IO_LAST      8'h1F
`define ABU_FLG_C        0
`define ABU_FLG_Z        1
`define ABU_FLG_I        7
`define ABU_MASK_ARITH   8'h3F
`define ABU_MASK_LOGIC   8'h0E
`define ABU_MASK_WORD    8'h1F
`define ABU_MASK_MUL     8'h03
`define ABU_MASK_IRQ     8'h80
`define ABU_CYC_1        3'h1
`define ABU_CYC_2        3'h2
`define ABU_CYC_3        3'h3
`define ABU_CYC_4        3'h4
`define ABU_CNT_ONE      3'h1
`define ABU_OP_ADD       6'h00
`define ABU_OP_ADC       6'h01
`define ABU_OP_WSUM      6'h02
`define ABU_OP_SUB       6'h03
`define ABU_OP_SBC       6'h04
`define ABU_OP_WDIFF     6'h05
`define ABU_OP_AND       6'h06
`define ABU_OP_OR        6'h07
`define ABU_OP_XOR       6'h08
`define ABU_OP_ONES      6'h09
`define ABU_OP_TWOS      6'h0A
`define ABU_OP_INC       6'h0B
`define ABU_OP_DEC       6'h0C
`define ABU_OP_SETBITS   6'h0D
`define ABU_OP_CLRBITS   6'h0E
`define ABU_OP_TEST      6'h0F
`define ABU_OP_ZERO      6'h10
`define ABU_OP_ONESET    6'h11
`define ABU_OP_MUL       6'h12
`define ABU_OP_SIGNED_PRODUCT      6'h13
`define ABU_OP_MIXED_SIGN_PRODUCT     6'h14
`define ABU_OP_FRACTIONAL_PRODUCT      6'h15
`define ABU_OP_FRACTIONAL_SIGNED_PRODUCT     6'h16
`define ABU_OP_FRACTIONAL_MIXED_PRODUCT    6'h17
`define ABU_OP_RELATIVE_JUMP      6'h18
`define ABU_OP_PJMP      6'h19
`define ABU_OP_RELATIVE_SUBROUTINE_CALL     6'h1A
`define ABU_OP_PCALL     6'h1B
`define ABU_OP_SUBEXIT   6'h1C
`define ABU_OP_IRQEXIT   6'h1D
`define ABU_OP_EQSKIP    6'h1E
`define ABU_OP_CMP       6'h1F
`define ABU_OP_CMPC      6'h20
`define ABU_OP_SKRLOW    6'h21
`define ABU_OP_SKRHIGH   6'h22
`define ABU_OP_SKIOLOW   6'h23
`define ABU_OP_SKIOHIGH  6'h24
`define ABU_OP_BRHIGH    6'h25
`define ABU_OP_BRLOW     6'h26
`define ABU_OP_IOSET     6'h27
`define ABU_OP_IOCLR     6'h28
`endif

// ---- src/abu_pkg.sv ----
// Types shared by the execution unit
package abu_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b100
  } abu_state_t;
endpackage

// ---- src/abu_top.sv ----
// Execution unit: ALU, status flags, branch, skip and I/O bit logic behind APB
`timescale 1ns/1ps
`include "abu_regs.svh"
module abu_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flag events from peripheral logic
  input  wire logic [4:0]  io_evt_idx,
  input  wire logic [7:0]  io_evt_set,
  // Execution state
  output logic             busy
);
  abu_pkg::abu_state_t state_reg, state_next;
  logic [10:0] cmd_reg;
  logic [15:0] opa_reg, opb_reg, pc_reg, zptr_reg, res_reg;
  logic [7:0]  status_register_reg, w1c_reg;
  logic [2:0]  cnt_reg, last_cyc_reg;
  logic        skip_reg, taken_reg, io_err_reg;
  logic [31:0] prdata_reg;
  logic [7:0]  io_mem [0:31];
  // Execution results
  logic [10:0] ar;
  logic [15:0] rv, res_next, pc_next;
  logic [7:0]  fm, nf, status_register_next, io_v;
  logic        res_wr, fh, fv, fc, fz, nmsb, zk, skp, tkn, io_wr, io_err;
  logic [2:0]  cyc;

  function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y,
                                       input logic ci);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    add8 = {(x[3] & y[3]) | (y[3] & ~s[3]) | (~s[3] & x[3]),
            (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]), s};
  endfunction
  function automatic logic [10:0] sub8(input logic [7:0] x, input logic [7:0] y,
                                       input logic ci);
    logic [8:0] s;
    s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
    sub8 = {(~x[3] & y[3]) | (y[3] & s[3]) | (s[3] & ~x[3]),
            (x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7]), s};
  endfunction
  function automatic logic [15:0] rel_tgt(input logic [15:0] p, input logic [11:0] k);
    rel_tgt = p + {{4{k[11]}}, k} + 16'h0001;
  endfunction

  // Flag bits written as one clear, others take the value
  function automatic logic [7:0] io_merge(input logic [7:0] old, input logic [7:0] v,
                                          input logic [7:0] m);
    io_merge = (v & ~m) | (old & ~v & m);
  endfunction

  // Decode
  wire logic [5:0]  op      = cmd_reg[5:0];
  wire logic        lng     = cmd_reg[6];
  wire logic [2:0]  fsel    = cmd_reg[10:8];
  wire logic [7:0]  a       = opa_reg[7:0];
  wire logic [7:0]  b       = opb_reg[7:0];
  wire logic        cin     = status_register_reg[`ABU_FLG_C];
  wire logic [7:0]  bitm    = 8'h01 << fsel;
  wire logic [7:0]  io_cur  = io_mem[opb_reg[4:0]];
  wire logic        io_ok   = opb_reg[7:0] <= `ABU_IO_LAST;
  wire logic        start   = psel & penable & pwrite & (paddr == `ABU_OFS_CMD)
                              & (state_reg == abu_pkg::ST_IDLE);
  wire logic        exec    = state_reg == abu_pkg::ST_EXEC;
  wire logic        sgn_a   = op inside {`ABU_OP_SIGNED_PRODUCT, `ABU_OP_MIXED_SIGN_PRODUCT,
                                         `ABU_OP_FRACTIONAL_SIGNED_PRODUCT, `ABU_OP_FRACTIONAL_MIXED_PRODUCT};
  wire logic        sgn_b   = op inside {`ABU_OP_SIGNED_PRODUCT, `ABU_OP_FRACTIONAL_SIGNED_PRODUCT};
  wire logic        frac    = op inside {`ABU_OP_FRACTIONAL_PRODUCT, `ABU_OP_FRACTIONAL_SIGNED_PRODUCT, `ABU_OP_FRACTIONAL_MIXED_PRODUCT};
  wire logic [15:0] ma      = {{8{sgn_a & a[7]}}, a};
  wire logic [15:0] mb      = {{8{sgn_b & b[7]}}, b};
  wire logic [31:0] pfull   = ma * mb;
  wire logic [15:0] prod    = pfull[15:0];
  wire logic [15:0] wsum    = opa_reg + {10'h000, opb_reg[5:0]};
  wire logic [15:0] wdif    = opa_reg - {10'h000, opb_reg[5:0]};

  always_comb
  begin
    ar = 11'h000;
    rv = 16'h0000;
    res_wr = 1'b0;
    fm = 8'h00;
    fh = 1'b0;
    fv = 1'b0;
    fc = 1'b0;
    zk = 1'b0;
    nmsb = 1'b0;
    pc_next = pc_reg + 16'h0001;
    cyc = `ABU_CYC_1;
    skp = 1'b0;
    tkn = 1'b0;
    io_wr = 1'b0;
    io_v = io_cur;
    io_err = 1'b0;
    case (op)
      `ABU_OP_ADD, `ABU_OP_ADC:
      begin
        ar = add8(a, b, (op == `ABU_OP_ADC) & cin);
        fm = `ABU_MASK_ARITH;
        res_wr = 1'b1;
      end
      `ABU_OP_SUB, `ABU_OP_SBC, `ABU_OP_CMP, `ABU_OP_CMPC:
      begin
        ar = sub8(a, b, (op == `ABU_OP_SBC || op == `ABU_OP_CMPC) & cin);
        zk = op == `ABU_OP_SBC || op == `ABU_OP_CMPC;
        fm = `ABU_MASK_ARITH;
        res_wr = op == `ABU_OP_SUB || op == `ABU_OP_SBC;
      end
      `ABU_OP_TWOS:
      begin
        ar = sub8(8'h00, a, 1'b0);
        fm = `ABU_MASK_ARITH;
        res_wr = 1'b1;
      end
      `ABU_OP_AND, `ABU_OP_TEST, `ABU_OP_CLRBITS:
      begin
        ar = {3'b000, a & (op == `ABU_OP_TEST ? a : op == `ABU_OP_CLRBITS ? ~b : b)};
        fm = `ABU_MASK_LOGIC;
        res_wr = 1'b1;
      end
      `ABU_OP_OR, `ABU_OP_SETBITS:
      begin
        ar = {3'b000, a | b};
        fm = `ABU_MASK_LOGIC;
        res_wr = 1'b1;
      end
      `ABU_OP_XOR, `ABU_OP_ZERO:
      begin
        ar = {3'b000, a ^ (op == `ABU_OP_ZERO ? a : b)};
        fm = `ABU_MASK_LOGIC;
        res_wr = 1'b1;
      end
      `ABU_OP_ONES:
      begin
        ar = {3'b001, ~a};
        fm = `ABU_MASK_WORD;
        res_wr = 1'b1;
      end
      `ABU_OP_INC, `ABU_OP_DEC:
      begin
        ar[9] = (op == `ABU_OP_INC) ? (a == 8'h7F) : (a == 8'h80);
        ar[7:0] = (op == `ABU_OP_INC) ? a + 8'h01 : a - 8'h01;
        fm = `ABU_MASK_LOGIC;
        res_wr = 1'b1;
      end
      `ABU_OP_ONESET:
      begin
        ar = {3'b000, 8'hFF};
        res_wr = 1'b1;
      end
      default:
        ar = 11'h000;
    endcase
    rv = {8'h00, ar[7:0]};
    nmsb = ar[7];
    fc = ar[8];
    fv = ar[9];
    fh = ar[10];
    case (op)
      `ABU_OP_WSUM, `ABU_OP_WDIFF:
      begin
        rv = (op == `ABU_OP_WSUM) ? wsum : wdif;
        nmsb = rv[15];
        fv = (op == `ABU_OP_WSUM) ? ~opa_reg[15] & rv[15] : opa_reg[15] & ~rv[15];
        fc = (op == `ABU_OP_WSUM) ? opa_reg[15] & ~rv[15] : ~opa_reg[15] & rv[15];
        fm = `ABU_MASK_WORD;
        res_wr = 1'b1;
        cyc = `ABU_CYC_2;
      end
      `ABU_OP_MUL, `ABU_OP_SIGNED_PRODUCT, `ABU_OP_MIXED_SIGN_PRODUCT,
      `ABU_OP_FRACTIONAL_PRODUCT, `ABU_OP_FRACTIONAL_SIGNED_PRODUCT, `ABU_OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        rv = frac ? {prod[14:0], 1'b0} : prod;
        fc = prod[15];
        fm = `ABU_MASK_MUL;
        res_wr = 1'b1;
        cyc = `ABU_CYC_2;
      end
      `ABU_OP_RELATIVE_JUMP, `ABU_OP_RELATIVE_SUBROUTINE_CALL:
      begin
        pc_next = rel_tgt(pc_reg, opb_reg[11:0]);
        cyc = (op == `ABU_OP_RELATIVE_JUMP) ? `ABU_CYC_2 : `ABU_CYC_3;
      end
      `ABU_OP_PJMP, `ABU_OP_PCALL:
      begin
        pc_next = zptr_reg;
        cyc = (op == `ABU_OP_PJMP) ? `ABU_CYC_2 : `ABU_CYC_3;
      end
      `ABU_OP_SUBEXIT, `ABU_OP_IRQEXIT:
      begin
        pc_next = opb_reg;
        fm = (op == `ABU_OP_IRQEXIT) ? `ABU_MASK_IRQ : 8'h00;
        cyc = `ABU_CYC_4;
      end
      `ABU_OP_EQSKIP:
        skp = a == b;
      `ABU_OP_SKRLOW, `ABU_OP_SKRHIGH:
        skp = ((a & bitm) != 8'h00) == (op == `ABU_OP_SKRHIGH);
      `ABU_OP_SKIOLOW, `ABU_OP_SKIOHIGH:
      begin
        skp = io_ok & (((io_cur & bitm) != 8'h00) == (op == `ABU_OP_SKIOHIGH));
        io_err = ~io_ok;
      end
      `ABU_OP_BRHIGH, `ABU_OP_BRLOW:
      begin
        // Named branches are these two with a fixed flag select
        tkn = status_register_reg[fsel] == (op == `ABU_OP_BRHIGH);
        if (tkn)
        begin
          pc_next = rel_tgt(pc_reg, {{5{opb_reg[6]}}, opb_reg[6:0]});
          cyc = `ABU_CYC_2;
        end
      end
      `ABU_OP_IOSET, `ABU_OP_IOCLR:
      begin
        io_v = (op == `ABU_OP_IOSET) ? io_cur | bitm : io_cur & ~bitm;
        io_wr = io_ok;
        io_err = ~io_ok;
        cyc = `ABU_CYC_2;
      end
      default:
        skp = 1'b0;
    endcase
    if (skp)
    begin
      pc_next = pc_reg + (lng ? 16'h0003 : 16'h0002);
      cyc = lng ? `ABU_CYC_3 : `ABU_CYC_2;
    end
  end

  assign fz = (rv == 16'h0000) & (~zk | status_register_reg[`ABU_FLG_Z]);
  assign nf = {1'b1, 1'b0, fh, nmsb ^ fv, fv, nmsb, fz, fc};
  assign status_register_next = (status_register_reg & ~fm) | (nf & fm);
  assign res_next = res_wr ? rv : res_reg;
  assign busy = state_reg != abu_pkg::ST_IDLE;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      abu_pkg::ST_IDLE:
        state_next = start ? abu_pkg::ST_EXEC : abu_pkg::ST_IDLE;
      abu_pkg::ST_EXEC:
        state_next = (cyc == `ABU_CYC_1) ? abu_pkg::ST_IDLE : abu_pkg::ST_WAIT;
      abu_pkg::ST_WAIT:
        state_next = (cnt_reg == `ABU_CNT_ONE) ? abu_pkg::ST_IDLE : abu_pkg::ST_WAIT;
      default:
        state_next = abu_pkg::ST_IDLE;
    endcase
  end

  // APB: no wait states; writes are refused while an operation runs
  wire logic acc     = psel & penable;
  wire logic is_io   = paddr[7] & (paddr[1:0] == 2'b00);
  wire logic is_reg  = ~paddr[7] & (paddr[1:0] == 2'b00) & (paddr <= `ABU_OFS_W1C);
  wire logic ro      = (paddr == `ABU_OFS_RESULT) || (paddr == `ABU_OFS_STAT);
  wire logic wr_ok   = acc & pwrite & ~busy & ((is_reg & ~ro) | is_io);
  wire logic [31:0] rd_val =
      is_io                      ? {24'h000000, io_mem[paddr[6:2]]} :
      paddr == `ABU_OFS_CMD      ? {21'h000000, cmd_reg} :
      paddr == `ABU_OFS_OPA      ? {16'h0000, opa_reg} :
      paddr == `ABU_OFS_OPB      ? {16'h0000, opb_reg} :
      paddr == `ABU_OFS_PC       ? {16'h0000, pc_reg} :
      paddr == `ABU_OFS_ZPTR     ? {16'h0000, zptr_reg} :
      paddr == `ABU_OFS_STATUS_REGISTER     ? {24'h000000, status_register_reg} :
      paddr == `ABU_OFS_RESULT   ? {16'h0000, res_reg} :
      paddr == `ABU_OFS_STAT     ? {25'h0000000, last_cyc_reg, io_err_reg, taken_reg,
                                    skip_reg, busy} :
      paddr == `ABU_OFS_W1C      ? {24'h000000, w1c_reg} : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = acc & (~(is_reg | is_io) | (pwrite & (busy | ro)));
  assign prdata = prdata_reg;

  always_ff @(posedge clk)
    if (rst)
      prdata_reg <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata_reg <= rd_val;

  always_ff @(posedge clk)
    if (rst)
    begin
      state_reg <= abu_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= exec ? cyc - `ABU_CNT_ONE : cnt_reg - `ABU_CNT_ONE;
    end

  always_ff @(posedge clk)
    if (rst)
    begin
      cmd_reg <= 11'h000;
      opa_reg <= 16'h0000;
      opb_reg <= 16'h0000;
      zptr_reg <= 16'h0000;
      w1c_reg <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (paddr == `ABU_OFS_CMD)
        cmd_reg <= pwdata[10:0];
      if (paddr == `ABU_OFS_OPA)
        opa_reg <= pwdata[15:0];
      if (paddr == `ABU_OFS_OPB)
        opb_reg <= pwdata[15:0];
      if (paddr == `ABU_OFS_ZPTR)
        zptr_reg <= pwdata[15:0];
      if (paddr == `ABU_OFS_W1C)
        w1c_reg <= pwdata[7:0];
    end

  always_ff @(posedge clk)
    if (rst)
    begin
      pc_reg <= 16'h0000;
      status_register_reg <= 8'h00;
      res_reg <= 16'h0000;
      skip_reg <= 1'b0;
      taken_reg <= 1'b0;
      io_err_reg <= 1'b0;
      last_cyc_reg <= 3'h0;
    end
    else if (exec)
    begin
      pc_reg <= pc_next;
      status_register_reg <= status_register_next;
      res_reg <= res_next;
      skip_reg <= skp;
      taken_reg <= tkn;
      io_err_reg <= io_err;
      last_cyc_reg <= cyc;
    end
    else if (wr_ok & (paddr == `ABU_OFS_PC))
      pc_reg <= pwdata[15:0];
    else if (wr_ok & (paddr == `ABU_OFS_STATUS_REGISTER))
      status_register_reg <= pwdata[7:0];

  // Peripheral flag events win over a clearing write in the same cycle
  always_ff @(posedge clk)
    if (rst)
      for (int i = 0; i < 32; i++)
        io_mem[i] <= 8'h00;
    else
      for (int i = 0; i < 32; i++)
        io_mem[i] <= ((exec & io_wr & (opb_reg[4:0] == 5'(i))) ?
                      io_merge(io_mem[i], io_v, w1c_reg) :
                      (wr_ok & is_io & (paddr[6:2] == 5'(i))) ?
                      io_merge(io_mem[i], pwdata[7:0], w1c_reg) : io_mem[i])
                     | ((io_evt_idx == 5'(i)) ? io_evt_set : 8'h00);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_busy2;
    busy ##1 busy ##1 !busy;
  endsequence
  sequence s_busy3;
    busy [*3] ##1 !busy;
  endsequence
  a_add_sum: assert property (exec && op == `ABU_OP_ADD |=>
      res_reg[7:0] == 8'($past(opa_reg[7:0]) + $past(opb_reg[7:0])))
    else $error("add result wrong");
  a_word_time: assert property (exec && op == `ABU_OP_WSUM |-> s_busy2)
    else $error("word sum not two cycles");
  a_logic_flags: assert property (exec && op == `ABU_OP_AND |=>
      !status_register_reg[3] && (status_register_reg & 8'h31) == ($past(status_register_reg) & 8'h31))
    else $error("logic op touched wrong flags");
  a_all_ones: assert property (exec && op == `ABU_OP_ONESET |=>
      $stable(status_register_reg) && res_reg == 16'h00FF)
    else $error("all ones changed flags");
  a_mul_time: assert property (exec && op == `ABU_OP_MUL |-> s_busy2)
    else $error("product not two cycles");
  a_ptr_jump: assert property (exec && op == `ABU_OP_PJMP |=> pc_reg == $past(zptr_reg))
    else $error("pointer jump target wrong");
  a_call_time: assert property (exec && op == `ABU_OP_RELATIVE_SUBROUTINE_CALL |-> s_busy3)
    else $error("relative call not three cycles");
  a_branch_take: assert property (exec && op == `ABU_OP_BRLOW |=>
      taken_reg == !$past(status_register_reg[fsel]))
    else $error("branch decision wrong");
  a_io_range: assert property (exec && op == `ABU_OP_IOSET && !io_ok |=>
      io_err_reg && $stable(pc_reg) == 1'b0)
    else $error("out of range io op not flagged");
  a_cmp_keep: assert property (exec && op == `ABU_OP_CMP |=> $stable(res_reg))
    else $error("compare stored result");
endmodule

// ---- testbench/abu_evt_src.sv ----
// Peripheral flag event source feeding the execution unit's event inputs
`timescale 1ns/1ps
module abu_evt_src (
  // Clock
  input  wire logic       clk,
  // Flag events
  output logic      [4:0] io_evt_idx,
  output logic      [7:0] io_evt_set
);
  initial
  begin
    io_evt_idx = 5'h00;
    io_evt_set = 8'h00;
  end

  // One-cycle event, then back to zero so an idle source sets nothing
  task fire(input logic [4:0] idx, input logic [7:0] bits);
    @(posedge clk);
    io_evt_idx <= idx;
    io_evt_set <= bits;
    @(posedge clk);
    io_evt_idx <= 5'h00;
    io_evt_set <= 8'h00;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the execution unit over APB
`timescale 1ns/1ps
`include "abu_regs.svh"
module tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  io_evt_idx;
  logic [7:0]  io_evt_set;
  logic        busy;
  logic [31:0] rd;
  logic        err;
  logic        tk;
  int          error_cnt;
  int          num_checks;
  int          s;
  int          v;
  int          h;

  abu_top dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_evt_idx(io_evt_idx), .io_evt_set(io_evt_set), .busy(busy)
  );

  abu_evt_src u_evt (.clk(clk), .io_evt_idx(io_evt_idx), .io_evt_set(io_evt_set));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task test_done;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high; read data taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      error_cnt++;
      test_done;
    end
  endtask

  // Poll until idle; a zero count skips the cycle figure
  task wait_idle(input logic [2:0] cyc);
    int i;
    for (i = 0; i < 20; i++)
    begin
      apb(1'b0, `ABU_OFS_STAT, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    if (i == 20)
    begin
      error_cnt++;
      test_done;
    end
    if (cyc != 3'h0)
      chk(32'(rd[6:4]), 32'(cyc));
    chk(32'(busy), 32'h0);
  endtask

  task run(input logic [5:0] op, input logic [2:0] sel, input logic two, input logic [2:0] cyc);
    apb(1'b1, `ABU_OFS_CMD, {21'h0, sel, 1'b0, two, op});
    wait_idle(cyc);
  endtask

  task alu(input logic [5:0] op, input logic [15:0] a, input logic [15:0] b,
           input logic [7:0] pre, input logic [15:0] eres, input logic [7:0] esr,
           input logic [2:0] cyc);
    apb(1'b1, `ABU_OFS_OPA, 32'(a));
    apb(1'b1, `ABU_OFS_OPB, 32'(b));
    apb(1'b1, `ABU_OFS_STATUS_REGISTER, 32'(pre));
    run(op, 3'h0, 1'b0, cyc);
    apb(1'b0, `ABU_OFS_RESULT, 32'h0);
    chk(rd, 32'(eres));
    apb(1'b0, `ABU_OFS_STATUS_REGISTER, 32'h0);
    chk(rd, 32'(esr));
  endtask

  task flow(input logic [5:0] op, input logic [2:0] sel, input logic two,
            input logic [15:0] a, input logic [15:0] b, input logic [15:0] pc,
            input logic [7:0] pre, input logic [15:0] epc, input logic [7:0] esr,
            input logic [2:0] cyc);
    apb(1'b1, `ABU_OFS_OPA, 32'(a));
    apb(1'b1, `ABU_OFS_OPB, 32'(b));
    apb(1'b1, `ABU_OFS_PC, 32'(pc));
    apb(1'b1, `ABU_OFS_STATUS_REGISTER, 32'(pre));
    run(op, sel, two, cyc);
    apb(1'b0, `ABU_OFS_PC, 32'h0);
    chk(rd, 32'(epc));
    apb(1'b0, `ABU_OFS_STATUS_REGISTER, 32'h0);
    chk(rd, 32'(esr));
  endtask

  initial
  begin
    rst = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (s = 0; s <= 32; s += 4)
    begin
      apb(1'b0, 8'(s), 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h0);
    end
    alu(`ABU_OP_ADD, 16'h000F, 16'h0001, 8'hC0, 16'h0010, 8'hE0, 3'h1);
    alu(`ABU_OP_ADC, 16'h007F, 16'h0000, 8'hC1, 16'h0080, 8'hEC, 3'h1);
    alu(`ABU_OP_SBC, 16'h0001, 16'h0000, 8'hC1, 16'h0000, 8'hC0, 3'h1);
    alu(`ABU_OP_SUB, 16'h0010, 16'h0001, 8'hC0, 16'h000F, 8'hE0, 3'h1);
    alu(`ABU_OP_CMP, 16'h0010, 16'h0010, 8'hC0, 16'h000F, 8'hC2, 3'h1);
    alu(`ABU_OP_CMPC, 16'h0000, 16'h0000, 8'hD3, 16'h000F, 8'hF5, 3'h1);
    alu(`ABU_OP_AND, 16'h00F0, 16'h008F, 8'hF9, 16'h0080, 8'hF5, 3'h1);
    alu(`ABU_OP_OR, 16'h0000, 16'h0000, 8'hE5, 16'h0000, 8'hE3, 3'h1);
    alu(`ABU_OP_XOR, 16'h00AA, 16'h00AA, 8'hE4, 16'h0000, 8'hE2, 3'h1);
    alu(`ABU_OP_SETBITS, 16'h0001, 16'h0080, 8'hF1, 16'h0081, 8'hF5, 3'h1);
    alu(`ABU_OP_CLRBITS, 16'h0081, 16'h0001, 8'hF1, 16'h0080, 8'hF5, 3'h1);
    alu(`ABU_OP_TEST, 16'h0000, 16'h0000, 8'hE4, 16'h0000, 8'hE2, 3'h1);
    alu(`ABU_OP_ZERO, 16'h005A, 16'h0000, 8'hE4, 16'h0000, 8'hE2, 3'h1);
    alu(`ABU_OP_ONESET, 16'h0000, 16'h0000, 8'h2A, 16'h00FF, 8'h2A, 3'h1);
    alu(`ABU_OP_INC, 16'h007F, 16'h0000, 8'hE1, 16'h0080, 8'hED, 3'h1);
    alu(`ABU_OP_DEC, 16'h0080, 16'h0000, 8'hF0, 16'h007F, 8'hF8, 3'h1);
    alu(`ABU_OP_ONES, 16'h0000, 16'h0000, 8'hF0, 16'h00FF, 8'hF5, 3'h1);
    alu(`ABU_OP_TWOS, 16'h0001, 16'h0000, 8'hD0, 16'h00FF, 8'hF5, 3'h1);
    alu(`ABU_OP_WSUM, 16'hFFFF, 16'h0001, 8'hE0, 16'h0000, 8'hE3, 3'h2);
    alu(`ABU_OP_WDIFF, 16'h0000, 16'h003F, 8'hE0, 16'hFFC1, 8'hF5, 3'h2);
    alu(`ABU_OP_MUL, 16'h00FF, 16'h00FF, 8'hFC, 16'hFE01, 8'hFD, 3'h2);
    alu(`ABU_OP_MUL, 16'h0000, 16'h0012, 8'h01, 16'h0000, 8'h02, 3'h2);
    alu(`ABU_OP_SIGNED_PRODUCT, 16'h00FF, 16'h0001, 8'hFC, 16'hFFFF, 8'hFD, 3'h2);
    alu(`ABU_OP_MIXED_SIGN_PRODUCT, 16'h0080, 16'h00FF, 8'hFC, 16'h8080, 8'hFD, 3'h2);
    alu(`ABU_OP_FRACTIONAL_PRODUCT, 16'h0080, 16'h0080, 8'hFF, 16'h8000, 8'hFC, 3'h2);
    alu(`ABU_OP_FRACTIONAL_SIGNED_PRODUCT, 16'h0080, 16'h0080, 8'hFF, 16'h8000, 8'hFC, 3'h2);
    alu(`ABU_OP_FRACTIONAL_MIXED_PRODUCT, 16'h00C0, 16'h0002, 8'hFC, 16'hFF00, 8'hFD, 3'h2);
    flow(`ABU_OP_RELATIVE_JUMP, 3'h0, 1'b0, 16'h0, 16'h0800, 16'h1000, 8'h5A, 16'h0801, 8'h5A, 3'h2);
    flow(`ABU_OP_RELATIVE_SUBROUTINE_CALL, 3'h0, 1'b0, 16'h0, 16'h07FF, 16'h0100, 8'h5A, 16'h0900, 8'h5A, 3'h3);
    apb(1'b1, `ABU_OFS_ZPTR, 32'h0000BEEF);
    flow(`ABU_OP_PJMP, 3'h0, 1'b0, 16'h0, 16'h0, 16'h0100, 8'hA5, 16'hBEEF, 8'hA5, 3'h2);
    flow(`ABU_OP_PCALL, 3'h0, 1'b0, 16'h0, 16'h0, 16'h0100, 8'hA5, 16'hBEEF, 8'hA5, 3'h3);
    flow(`ABU_OP_SUBEXIT, 3'h0, 1'b0, 16'h0, 16'h1234, 16'h0100, 8'h00, 16'h1234, 8'h00, 3'h4);
    flow(`ABU_OP_IRQEXIT, 3'h0, 1'b0, 16'h0, 16'h4321, 16'h0100, 8'h01, 16'h4321, 8'h81, 3'h4);
    // Every flag select, both polarities, flag high and low
    for (s = 0; s < 8; s++)
      for (v = 0; v < 2; v++)
        for (h = 0; h < 2; h++)
        begin
          tk = (v == h);
          flow(h ? `ABU_OP_BRHIGH : `ABU_OP_BRLOW, 3'(s), 1'b0, 16'h0, 16'h0040, 16'h0100,
               8'(v << s), tk ? 16'h00C1 : 16'h0101, 8'(v << s), tk ? 3'h2 : 3'h1);
          apb(1'b0, `ABU_OFS_STAT, 32'h0);
          chk(32'(rd[2]), 32'(tk));
        end
    flow(`ABU_OP_EQSKIP, 3'h0, 1'b0, 16'h55, 16'h55, 16'h0100, 8'h5A, 16'h0102, 8'h5A, 3'h2);
    flow(`ABU_OP_EQSKIP, 3'h0, 1'b1, 16'h55, 16'h55, 16'h0100, 8'h5A, 16'h0103, 8'h5A, 3'h3);
    flow(`ABU_OP_EQSKIP, 3'h0, 1'b0, 16'h55, 16'h54, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h1);
    flow(`ABU_OP_SKRLOW, 3'h3, 1'b0, 16'hF7, 16'h0, 16'h0100, 8'h5A, 16'h0102, 8'h5A, 3'h2);
    flow(`ABU_OP_SKRHIGH, 3'h3, 1'b0, 16'hF7, 16'h0, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h1);
    flow(`ABU_OP_SKRHIGH, 3'h7, 1'b1, 16'h80, 16'h0, 16'h0100, 8'h5A, 16'h0103, 8'h5A, 3'h3);
    apb(1'b1, 8'h88, 32'h10);
    flow(`ABU_OP_SKIOHIGH, 3'h4, 1'b0, 16'h0, 16'h02, 16'h0100, 8'h5A, 16'h0102, 8'h5A, 3'h2);
    flow(`ABU_OP_SKIOLOW, 3'h4, 1'b0, 16'h0, 16'h02, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h1);
    flow(`ABU_OP_SKIOLOW, 3'h0, 1'b1, 16'h0, 16'h02, 16'h0100, 8'h5A, 16'h0103, 8'h5A, 3'h3);
    // Flag bit 7 of every I/O register clears on writing one
    apb(1'b1, `ABU_OFS_W1C, 32'h80);
    apb(1'b1, 8'h94, 32'h01);
    u_evt.fire(5'h05, 8'h80);
    apb(1'b0, 8'h94, 32'h0);
    chk(rd, 32'h81);
    flow(`ABU_OP_IOSET, 3'h1, 1'b0, 16'h0, 16'h05, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h2);
    apb(1'b0, 8'h94, 32'h0);
    chk(rd, 32'h03);
    flow(`ABU_OP_IOCLR, 3'h0, 1'b0, 16'h0, 16'h05, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h2);
    apb(1'b0, 8'h94, 32'h0);
    chk(rd, 32'h02);
    flow(`ABU_OP_IOSET, 3'h0, 1'b0, 16'h0, 16'h1F, 16'h0100, 8'h5A, 16'h0101, 8'h5A, 3'h2);
    apb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h01);
    apb(1'b1, `ABU_OFS_OPB, 32'h20);
    run(`ABU_OP_IOSET, 3'h0, 1'b0, 3'h0);
    chk(32'(rd[3]), 32'h1);
    // Writes during a running operation and to the result register, and reads of unmapped places, are refused
    apb(1'b1, `ABU_OFS_STATUS_REGISTER, 32'h00);
    apb(1'b1, `ABU_OFS_CMD, 32'(`ABU_OP_SUBEXIT));
    apb(1'b1, `ABU_OFS_STATUS_REGISTER, 32'hFF);
    chk(32'(err), 32'h1);
    wait_idle(3'h4);
    apb(1'b0, `ABU_OFS_STATUS_REGISTER, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 8'h24, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, `ABU_OFS_RESULT, 32'h0);
    chk(32'(err), 32'h1);
    test_done;
  end
endmodule
